/* File: logic/hrs_host_resp.sv */
// Purpose: host-bus response encoding and special cycle handling
// Assumes: request decode, snoop and address routing arrive with the request
// Notes: responses leave in request order through a small in-order queue
`timescale 1ns/1ps
`default_nettype none
module hrs_host_resp
    import hrs_pkg::*;
#(
    parameter int IOQ_DEPTH = IOQ_DEPTH_DEF
) (
    // clock and reset
    input  wire logic     ref_clk,
    input  wire logic     resetn,
    // processor request
    input  wire hrs_req_s req,
    input  wire hrs_attr_s attr,
    // hub link special cycle completion
    input  wire logic     hub_done,
    input  wire logic     hub_master_abort,
    // response phase
    output logic          resp_status_bit2_n,
    output logic          resp_status_bit1_n,
    output logic          resp_status_bit0_n,
    output logic          resp_valid,
    output logic          ioq_full,
    // hub link special cycle request
    output logic          hub_sc_valid,
    output hrs_hub_e      hub_sc_type,
    // special cycle and management status
    output logic          sc_claimed,
    output logic          system_management_mode,
    output logic          smm_space_access
);
    localparam int PTR_W = (IOQ_DEPTH > 1) ? $clog2(IOQ_DEPTH) : 1;
    localparam int CNT_W = PTR_W + 1;
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(IOQ_DEPTH - 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(IOQ_DEPTH);
    localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
    localparam logic [PTR_W-1:0] PTR_ONE  = PTR_W'(1);

    // pointer advance with wrap at any depth
    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        ptr_inc = (p == PTR_LAST) ? '0 : p + PTR_ONE;
    endfunction

    // logical code to pin levels; the pins are active low
    function automatic logic [2:0] code_to_pins(input logic [2:0] c);
        code_to_pins = ~c;
    endfunction

    // special cycle action by type
    function automatic hrs_ent_s special_entry(input logic [7:0] t);
        hrs_ent_s e;
        e.hub_op = HUB_NONE;
        e.code   = RSP_NODATA;
        unique case (t)
            SC_NOP: e.code = RSP_NODATA;
            SC_SHUTDOWN: begin
                e.hub_op = HUB_SHUTDOWN;
                e.code   = RSP_RETRY;
            end
            SC_FLUSH: e.code = RSP_RETRY;
            SC_HALT: begin
                e.hub_op = HUB_HALT;
                e.code   = RSP_RETRY;
            end
            SC_SYNC: e.code = RSP_RETRY;
            SC_FLUSHACK: e.code = RSP_NODATA;
            SC_STOPGNT: begin
                e.hub_op = HUB_STOPGNT;
                e.code   = RSP_NODATA;
            end
            SC_SMIACK: e.code = RSP_NODATA;
            default: e.code = RSP_NODATA;
        endcase
        return e;
    endfunction

    // response code for an ordinary transaction
    function automatic logic [2:0] normal_code(input logic [4:0] ra,
                                               input logic [4:0] rb,
                                               input hrs_attr_s a);
        logic mrd;
        logic mwr;
        logic iord;
        logic iowr;
        logic iack;
        logic rd;
        logic wr;
        logic can_retry;
        logic can_defer;
        mrd  = (ra == REQA_MRDINV) || (ra == REQA_MCODE) || (ra == REQA_MDATA);
        mwr  = (ra == REQA_MWR_NR) || (ra == REQA_MWR);
        iord = (ra == REQA_IORD);
        iowr = (ra == REQA_IOWR);
        iack = (ra == REQA_SPECIAL) && (rb == REQB_INTACK);
        rd   = mrd || iord || iack;
        wr   = mwr || iowr;
        // hub reads and writes, locked dram reads
        can_retry = (a.to_hub && (rd || wr)) ||
                    (!a.to_hub && !a.to_gfx && a.locked && mrd);
        // hub reads and io writes, graphics likewise
        can_defer = (a.to_hub && (rd || iowr)) ||
                    (a.to_gfx && (mrd || iord || iowr));
        // modified snoop hit wins over everything
        if (a.snoop_hitm)
            return RSP_IWB;
        // retry to dodge deadlock on a blocked resource
        if (a.blocked && can_retry)
            return RSP_RETRY;
        if (a.defer_en && can_defer)
            return RSP_DEFER;
        // writes and zero-length reads carry no data
        if (!rd || a.zero_len)
            return RSP_NODATA;
        // reads return data with the response
        return RSP_DATA;
    endfunction

    // asserted-sense views of the request pins
    logic [4:0] req_a;
    logic [4:0] req_b;
    logic [7:0] sc_type;
    logic       smm_flag;
    logic       is_special;
    logic       push;
    logic       pop;
    hrs_ent_s   new_ent;
    hrs_ent_s   head;
    logic [2:0] head_pins;
    logic [2:0] idle_pins;

    // first address phase never looked at
    assign req_a    = ~req.req_type_phase_one_n;
    assign req_b    = ~req.req_type_phase_two_n;
    assign sc_type  = ~req.addr_phase_two_type_n;
    assign smm_flag = ~req.sysmgmt_space_flag_n;
    assign is_special = (req_a == REQA_SPECIAL) && (req_b[2:0] == REQB_SPEC_LO);

    // in-order queue storage and pointers
    hrs_ent_s         ent_q [IOQ_DEPTH];
    logic [PTR_W-1:0] wr_ptr_r;
    logic [PTR_W-1:0] rd_ptr_r;
    logic [CNT_W-1:0] cnt_r;
    hrs_state_e       state_r;

    assign head = ent_q[rd_ptr_r];
    // pin levels for the head entry and for the idle bus
    assign head_pins = code_to_pins(head.code);
    assign idle_pins = code_to_pins(RSP_IDLE);
    // a full queue drops the request; the bus limits outstanding requests
    // limitation: a dropped request never gets a response phase
    assign push = req.valid && (cnt_r != CNT_FULL);

    // entry for the incoming request
    // special cycles ignore the attributes, so routing cannot alter them
    always_comb begin
        if (is_special) begin
            new_ent = special_entry(sc_type);
        end else begin
            new_ent.hub_op = HUB_NONE;
            new_ent.code   = normal_code(req_a, req_b, attr);
        end
    end

    // pop when the head has its answer ready
    always_comb begin
        pop = 1'b0;
        unique case (state_r)
            ST_IDLE:     pop = (cnt_r != '0) && (head.hub_op == HUB_NONE);
            ST_HUB_WAIT: pop = hub_done;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (push)
            ent_q[wr_ptr_r] <= new_ent;
    end

    // single head, read in arrival order
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r    <= '0;
        end else begin
            if (push)
                wr_ptr_r <= ptr_inc(wr_ptr_r);
            if (pop)
                rd_ptr_r <= ptr_inc(rd_ptr_r);
            if (push && !pop)
                cnt_r <= cnt_r + CNT_ONE;
            else if (pop && !push)
                cnt_r <= cnt_r - CNT_ONE;
        end
    end

    // full flag registered from the next count
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn)
            ioq_full <= 1'b0;
        else if (push && !pop)
            ioq_full <= (cnt_r + CNT_ONE) == CNT_FULL;
        else if (pop && !push)
            ioq_full <= 1'b0;
    end

    // hub special cycle held until the link ends it
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_r      <= ST_IDLE;
            hub_sc_valid <= 1'b0;
            hub_sc_type  <= HUB_NONE;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    // later entries wait behind the head, so none overtakes it
                    if (cnt_r != '0 && head.hub_op != HUB_NONE) begin
                        state_r      <= ST_HUB_WAIT;
                        hub_sc_valid <= 1'b1;
                        hub_sc_type  <= head.hub_op;
                    end
                end
                ST_HUB_WAIT: begin
                    // master abort is the normal end; any end releases it
                    if (hub_done) begin
                        state_r      <= ST_IDLE;
                        hub_sc_valid <= 1'b0;
                        hub_sc_type  <= HUB_NONE;
                    end
                end
            endcase
        end
    end

    // response phase drive, pins inverted from the code
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            resp_valid         <= 1'b0;
            resp_status_bit2_n <= 1'b1;
            resp_status_bit1_n <= 1'b1;
            resp_status_bit0_n <= 1'b1;
        end else if (pop) begin
            // one cycle per response; pins go back to idle unless another response follows
            resp_valid         <= 1'b1;
            resp_status_bit2_n <= head_pins[2];
            resp_status_bit1_n <= head_pins[1];
            resp_status_bit0_n <= head_pins[0];
        end else begin
            // idle between responses, only legal codes queued
            resp_valid         <= 1'b0;
            resp_status_bit2_n <= idle_pins[2];
            resp_status_bit1_n <= idle_pins[1];
            resp_status_bit0_n <= idle_pins[0];
        end
    end

    // claim pulse for every accepted special cycle
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn)
            sc_claimed <= 1'b0;
        else
            sc_claimed <= push && is_special;
    end

    // management mode opened and closed by smi acknowledge
    // takes effect at the take edge, not at the response
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            system_management_mode <= 1'b0;
        end else if (push && is_special && sc_type == SC_SMIACK) begin
            system_management_mode <= smm_flag;
        end
    end

    // management-space tag on later flagged accesses
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn)
            smm_space_access <= 1'b0;
        else
            // flagged access while the space is open
            smm_space_access <= push && !is_special && smm_flag && system_management_mode;
    end

    // hub_master_abort is not needed to end the cycle: any hub end
    // releases the head, so a faulty link end can never wedge the queue
    logic unused_abort;
    assign unused_abort = hub_master_abort;
endmodule
`default_nettype wire

/* File: logic/hrs_pkg.sv */
// Purpose: constants and types for the host response and special cycle logic
// Assumes: logical values below are asserted-high; pins are active low
// Notes:
// Functional notes
// - complete transactions strictly in arrival order
// - retry response code is 001
// - retry only hub accesses, locked dram reads
// - defer code 010 for eligible hub/graphics cycles
// - no-data 101 for writes, zero-length reads
// - implicit writeback 110 on modified snoop hit
// - normal data 111 for reads
// - special cycle is 01000 then xx001
// - ignore first address; type from second
// - type 00 is a side-effect-free no-op
// - shutdown: hub cycle, then retry
// - flush: claim and retry
// - halt: hub cycle, then retry
// - sync: claim and retry
// - flush acknowledge: claim and complete
// - stop grant: hub cycle, then complete
// - smi ack with flag enters management mode
// - smi ack never goes to hub
// - smi ack without flag closes space
package hrs_pkg;
    // response-status codes, asserted sense
    localparam logic [2:0] RSP_IDLE   = 3'h0;
    localparam logic [2:0] RSP_RETRY  = 3'h1;
    localparam logic [2:0] RSP_DEFER  = 3'h2;
    localparam logic [2:0] RSP_NODATA = 3'h5;
    localparam logic [2:0] RSP_IWB    = 3'h6;
    localparam logic [2:0] RSP_DATA   = 3'h7;
    // request-type encodings, first phase
    localparam logic [4:0] REQA_SPECIAL = 5'h08;
    localparam logic [4:0] REQA_MRDINV  = 5'h02;
    localparam logic [4:0] REQA_MCODE   = 5'h04;
    localparam logic [4:0] REQA_MDATA   = 5'h06;
    localparam logic [4:0] REQA_MWR_NR  = 5'h05;
    localparam logic [4:0] REQA_MWR     = 5'h07;
    localparam logic [4:0] REQA_IORD    = 5'h10;
    localparam logic [4:0] REQA_IOWR    = 5'h11;
    // second phase low bits: special vs interrupt acknowledge
    localparam logic [2:0] REQB_SPEC_LO = 3'h1;
    localparam logic [4:0] REQB_INTACK  = 5'h00;
    // special cycle types
    localparam logic [7:0] SC_NOP      = 8'h00;
    localparam logic [7:0] SC_SHUTDOWN = 8'h01;
    localparam logic [7:0] SC_FLUSH    = 8'h02;
    localparam logic [7:0] SC_HALT     = 8'h03;
    localparam logic [7:0] SC_SYNC     = 8'h04;
    localparam logic [7:0] SC_FLUSHACK = 8'h05;
    localparam logic [7:0] SC_STOPGNT  = 8'h06;
    localparam logic [7:0] SC_SMIACK   = 8'h07;
    localparam int IOQ_DEPTH_DEF = 4;

    typedef enum logic [1:0] {HUB_NONE, HUB_SHUTDOWN, HUB_HALT, HUB_STOPGNT} hrs_hub_e;
    typedef enum logic {ST_IDLE, ST_HUB_WAIT} hrs_state_e;

    // processor request, pin sense (active low except valid, which is active high)
    typedef struct packed {
        logic        valid;
        logic [4:0]  req_type_phase_one_n;
        logic [4:0]  req_type_phase_two_n;
        logic [32:0] addr_phase_one_n;
        logic [7:0]  addr_phase_two_type_n;
        logic        sysmgmt_space_flag_n;
    } hrs_req_s;

    // attributes from address decode and snoop, asserted high
    typedef struct packed {
        logic to_hub;
        logic to_gfx;
        logic locked;
        logic zero_len;
        logic snoop_hitm;
        logic blocked;
        logic defer_en;
    } hrs_attr_s;

    // one in-order queue entry
    typedef struct packed {
        hrs_hub_e   hub_op;
        logic [2:0] code;
    } hrs_ent_s;
endpackage

/* File: test/hrs_host_resp_asserts.sv */
// Purpose: port-level checks of the host response logic
// Assumes: pins active low, code is the inverse of the pins
// Notes: bound into every hrs_host_resp instance
`timescale 1ns/1ps
`default_nettype none
module hrs_host_resp_asserts
    import hrs_pkg::*;
#(
    parameter int IOQ_DEPTH = IOQ_DEPTH_DEF
) (
    // clock and reset
    input wire logic      ref_clk,
    input wire logic      resetn,
    // request side
    input wire hrs_req_s  req,
    input wire hrs_attr_s attr,
    input wire logic      hub_done,
    input wire logic      hub_master_abort,
    // response and status side
    input wire logic      resp_status_bit2_n,
    input wire logic      resp_status_bit1_n,
    input wire logic      resp_status_bit0_n,
    input wire logic      resp_valid,
    input wire logic      ioq_full,
    input wire logic      hub_sc_valid,
    input wire hrs_hub_e  hub_sc_type,
    input wire logic      sc_claimed,
    input wire logic      system_management_mode,
    input wire logic      smm_space_access
);
    logic       take;
    logic       spec;
    logic       system_management_interrupt;
    logic [2:0] code;
    // decode of what the block accepts this cycle
    assign take = req.valid && !ioq_full;
    assign spec = take && (~req.req_type_phase_one_n == REQA_SPECIAL)
                  && (~req.req_type_phase_two_n[2:0] == REQB_SPEC_LO);
    assign system_management_interrupt  = spec && (~req.addr_phase_two_type_n == SC_SMIACK);
    assign code = ~{resp_status_bit2_n, resp_status_bit1_n, resp_status_bit0_n};

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    chk_idle_pins: assert property (!resp_valid |-> code == RSP_IDLE)
        else $error("response pins not idle");
    chk_no_bad_code: assert property (resp_valid |-> code != 3'h4 && code != 3'h3)
        else $error("forbidden response code");
    chk_claim_take: assert property (spec |=> sc_claimed)
        else $error("special cycle not claimed");
    chk_claim_cause: assert property (sc_claimed |-> $past(spec))
        else $error("claim without special cycle");
    chk_smm_enter: assert property (system_management_interrupt && !req.sysmgmt_space_flag_n
        |=> system_management_mode) else $error("management mode not entered");
    chk_smm_exit: assert property (system_management_interrupt && req.sysmgmt_space_flag_n
        |=> !system_management_mode) else $error("management mode not left");
    chk_smm_space: assert property (take && !spec && system_management_mode
        && !req.sysmgmt_space_flag_n |=> smm_space_access) else $error("space access missed");
    chk_hub_hold: assert property (hub_sc_valid && !hub_done
        |=> hub_sc_valid && $stable(hub_sc_type)) else $error("hub request not held");
    chk_hub_end: assert property (hub_sc_valid && hub_done |=> resp_valid && !hub_sc_valid
        && code == ($past(hub_sc_type) == HUB_STOPGNT ? RSP_NODATA : RSP_RETRY))
        else $error("wrong end of hub special cycle");
endmodule
bind hrs_host_resp hrs_host_resp_asserts #(.IOQ_DEPTH(IOQ_DEPTH)) i_chk (.ref_clk, .resetn,
    .req, .attr, .hub_done, .hub_master_abort, .resp_status_bit2_n, .resp_status_bit1_n,
    .resp_status_bit0_n, .resp_valid, .ioq_full, .hub_sc_valid, .hub_sc_type, .sc_claimed,
    .system_management_mode, .smm_space_access);
`default_nettype wire

/* File: test/hrs_hub_model.sv */
// Purpose: far end of the hub link for special cycles
// Assumes: nobody on the hub claims these cycles
// Notes: lat sets the stall before the abort ends the cycle
`timescale 1ns/1ps
`default_nettype none
module hrs_hub_model (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    // hub request and stall length
    input  wire logic       hub_sc_valid,
    input  wire logic [5:0] lat,
    // termination
    output logic            hub_done,
    output logic            hub_master_abort
);
    logic [5:0] cnt_r;
    // master abort ending
    // unclaimed hub cycles always end by abort, after a chosen stall
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= 6'h00;
            hub_done <= 1'b0;
        end else if (hub_sc_valid && !hub_done) begin
            hub_done <= (cnt_r == lat);
            cnt_r <= (cnt_r == lat) ? 6'h00 : cnt_r + 6'h01;
        end else begin
            hub_done <= 1'b0;
        end
    end
    assign hub_master_abort = hub_done;
endmodule
`default_nettype wire

/* File: test/tb_host_response_special_cycle.sv */
// Purpose: self-checking bench for the host response logic
// Assumes: 10 MHz clock, pins active low
// Notes: monitors log responses and hub ends at each edge
`timescale 1ns/1ps
`default_nettype none
module tb_host_response_special_cycle;
    import hrs_pkg::*;
    logic       ref_clk = 1'b0;
    logic       resetn = 1'b0;
    hrs_req_s   req = '0;
    hrs_attr_s  attr = '0;
    logic [5:0] lat = 6'h00;
    wire  [2:0] pins;
    hrs_hub_e   hub_sc_type;
    logic       hub_done, hub_master_abort, resp_valid, ioq_full, hub_sc_valid;
    logic       sc_claimed, system_management_mode, smm_space_access;
    logic       seen_full = 1'b0;
    logic [2:0] rq[$];
    hrs_hub_e   hq[$];
    int         n_claim = 0, n_space = 0, miscompares = 0, total_checks = 0;
    // {first type, attributes, code}
    logic [14:0] ord_tab [12] = '{{5'h06, 7'h00, 3'h7}, {5'h07, 7'h00, 3'h5},
        {5'h06, 7'h04, 3'h6}, {5'h06, 7'h42, 3'h1}, {5'h10, 7'h41, 3'h2}, {5'h06, 7'h08, 3'h5},
        {5'h11, 7'h21, 3'h2}, {5'h04, 7'h02, 3'h7}, {5'h02, 7'h12, 3'h1}, {5'h07, 7'h21, 3'h5},
        {5'h08, 7'h41, 3'h2}, {5'h05, 7'h02, 3'h5}};
    // {special type, code, hub op}
    logic [12:0] sc_tab [9] = '{{8'h00, 3'h5, 2'h0}, {8'h01, 3'h1, 2'h1}, {8'h02, 3'h1, 2'h0},
        {8'h03, 3'h1, 2'h2}, {8'h04, 3'h1, 2'h0}, {8'h05, 3'h5, 2'h0}, {8'h06, 3'h5, 2'h3},
        {8'h07, 3'h5, 2'h0}, {8'h3c, 3'h5, 2'h0}};

    // clock at 100 ns period
    always #50 ref_clk = ~ref_clk;

    hrs_host_resp #(.IOQ_DEPTH(4)) i_dut (.ref_clk, .resetn, .req, .attr, .hub_done,
        .hub_master_abort, .resp_status_bit2_n(pins[2]), .resp_status_bit1_n(pins[1]),
        .resp_status_bit0_n(pins[0]), .resp_valid, .ioq_full, .hub_sc_valid, .hub_sc_type,
        .sc_claimed, .system_management_mode, .smm_space_access);
    hrs_hub_model i_hub (.ref_clk, .resetn, .hub_sc_valid, .lat, .hub_done, .hub_master_abort);

    // log settled outputs before this edge's updates land
    always @(posedge ref_clk) begin
        if (resp_valid === 1'b1) rq.push_back(~pins);
        if (hub_sc_valid === 1'b1 && hub_done === 1'b1) hq.push_back(hub_sc_type);
        if (sc_claimed === 1'b1) n_claim++;
        if (smm_space_access === 1'b1) n_space++;
        if (ioq_full === 1'b1) seen_full = 1'b1;
    end

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one request per call; address content varies since it must not matter
    task automatic put(input logic [4:0] t1, input logic [4:0] t2, input logic [7:0] ty,
                       input logic fl, input logic [6:0] at);
        @(posedge ref_clk);
        #5;
        req = {1'b1, ~t1, ~t2, {33{ty[0]}}, ~ty, ~fl};
        attr = at;
    endtask
    task automatic quiet();
        @(posedge ref_clk);
        #5;
        req.valid = 1'b0;
    endtask
    // wait, bounded, for n responses and make sure no more follow
    task automatic wait_n(input int n);
        for (int i = 0; i < 60 && rq.size() < n; i++) @(posedge ref_clk);
        repeat (3) @(posedge ref_clk);
        #5;
        chk("resp count", 8'(n), 8'(rq.size()));
    endtask

    task automatic t_ordinary();
        for (int g = 0; g < 12; g += 4) begin
            rq.delete();
            for (int k = g; k < g + 4; k++) begin
                put(ord_tab[k][14:10], 5'h00, 8'h00, 1'b0, ord_tab[k][9:3]);
            end
            quiet();
            wait_n(4);
            for (int k = g; k < g + 4; k++) begin
                chk("code", 8'(ord_tab[k][2:0]), 8'(rq.pop_front()));
            end
        end
    endtask
    task automatic t_special();
        for (int i = 0; i < 9; i++) begin
            rq.delete();
            hq.delete();
            n_claim = 0;
            lat = 6'(i * 3);
            put(REQA_SPECIAL, {i[1:0], REQB_SPEC_LO}, sc_tab[i][12:5], 1'b0, 7'h00);
            quiet();
            wait_n(1);
            chk("sc code", 8'(sc_tab[i][4:2]), 8'(rq.pop_front()));
            chk("sc claim", 8'h01, 8'(n_claim));
            chk("hub count", 8'(sc_tab[i][1:0] != 2'h0), 8'(hq.size()));
            if (hq.size() > 0) begin
                chk("hub type", 8'(sc_tab[i][1:0]), 8'(hq.pop_front()));
            end
        end
    endtask
    task automatic t_smm();
        rq.delete();
        hq.delete();
        n_space = 0;
        put(REQA_SPECIAL, 5'h01, SC_SMIACK, 1'b1, 7'h00);
        put(REQA_MDATA, 5'h00, 8'h00, 1'b1, 7'h00);
        put(REQA_MDATA, 5'h00, 8'h00, 1'b0, 7'h00);
        quiet();
        wait_n(3);
        chk("mode", 8'h01, 8'(system_management_mode));
        chk("space", 8'h01, 8'(n_space));
        put(REQA_SPECIAL, 5'h01, SC_SMIACK, 1'b0, 7'h00);
        put(REQA_MDATA, 5'h00, 8'h00, 1'b1, 7'h00);
        quiet();
        wait_n(5);
        chk("mode", 8'h00, 8'(system_management_mode));
        chk("space", 8'h01, 8'(n_space));
        chk("smi hub", 8'h00, 8'(hq.size()));
    endtask
    // stalled halt fills the queue; the fifth request is dropped
    task automatic t_full();
        rq.delete();
        seen_full = 1'b0;
        lat = 6'h1e;
        put(REQA_SPECIAL, 5'h01, SC_HALT, 1'b0, 7'h00);
        for (int k = 0; k < 4; k++) put(REQA_MDATA, 5'h00, 8'h00, 1'b0, 7'h00);
        quiet();
        wait_n(4);
        chk("full", 8'h01, 8'(seen_full));
        for (int k = 0; k < 4; k++) begin
            chk("order", (k == 0) ? 8'h01 : 8'h07, 8'(rq.pop_front()));
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // main sequence after five reset cycles
    initial begin
        repeat (5) @(posedge ref_clk);
        #5;
        resetn = 1'b1;
        t_ordinary();
        t_special();
        t_smm();
        t_full();
        report_and_stop();
    end
    // watchdog, far beyond the few hundred cycles expected
    initial begin
        #2000000;
        miscompares++;
        report_and_stop();
    end
endmodule
`default_nettype wire
